/* File: logic/bra_defs.svh */
`ifndef BRA_DEFS_SVH
`define BRA_DEFS_SVH
// Register byte offsets
`define REG_CONTROL        8'h00
`define REG_STATUS         8'h04
`define REG_TX_DATA        8'h08
`define REG_RX_DATA        8'h0c
`define REG_FLAGS          8'h10
// Control field positions
`define CTL_ENABLE         0
`define CTL_NT_SIDE        1
`define CTL_LOCAL_READY    2
`define CTL_START          3
`define CTL_ANNOUNCE_OFF   4
`define CTL_LOOPBACK       5
`define CTL_RESET_VALUE    32'h0000_0000
// Flags register field positions
`define FLG_TIMING         0
`define FLG_FRAME_SYNC     1
`define FLG_MF_MARKER      2
`define FLG_EC_CONV        3
`define FLG_RX_READY       4
`define FLG_RX_DEA         5
`define FLG_SIGNAL_OK      6
// Tone symbol codes, signed 3-level
`define SYM_PLUS3          2'b01
`define SYM_MINUS3         2'b11
`define TONE_HALF          3'h4
// Timing
`define CLK_HZ             10000000
`define LOSS_MS            480
`define LOSS_CYCLES        (`LOSS_MS * (`CLK_HZ / 1000))
`define REPEAT_MF          3
`define MF_BITS            12'h3c0
`define SF_PER_MF          4'h1
`define FILL_NT            8'hff
`define FILL_LT            8'h00
`endif

/* File: logic/bra_fifo.sv */
`timescale 1ns/1ns
module bra_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   wire              push = in_valid && in_ready;
   wire              pop  = out_valid && out_ready;

   // Honest full and empty from the fill count
   assign in_ready  = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data  = mem[rd_ptr];

   // Pointers wrap at the depth
   always_ff @(posedge clk) begin
      if (rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) begin
            mem[wr_ptr] <= in_data;
            wr_ptr      <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

/* File: logic/bra_line_ctrl.sv */
// Summary of operation
// - Tone is four +3 then four -3
// - Absent marker sends frame word instead
// - Normal overhead carries checksum, channel, indicators
// - Channel bits fixed fill until both ready; the code waits for the received readiness bit only, not local readiness
// - Final pattern runs until line off
// - Customer side transparent after operational, ready, announce
// - Customer operational: timing, sync, marker, converged
// - Line side transparent: operational, marker, ready
// - Line operational: timing, sync, marker, converged
// - Line side switches in boundary super frames
// - Transparent by second ready-one super frame
// - Both directions transparent within those frames
// - Readiness bit follows local layer-2 readiness
// - Lost readiness clears transmitted bit
// - Readiness change repeated three multiframes
// - Announce turn-off three multiframes before stopping
// - Signal loss over 480 ms resets receiver
//
// Added by the designer: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ns
`include "bra_defs.svh"
module bra_line_ctrl #(
   parameter int LOSS_CYCLES = `LOSS_CYCLES,
   parameter int FIFO_DEPTH  = 4
) (
   input  wire logic        CLK,
   input  wire logic        RST,
   // AXI4-Lite slave
   input  wire logic [7:0]  AWADDR,
   input  wire logic        AWVALID,
   output logic             AWREADY,
   input  wire logic [31:0] WDATA,
   input  wire logic [3:0]  WSTRB,
   input  wire logic        WVALID,
   output logic             WREADY,
   output logic [1:0]       BRESP,
   output logic             BVALID,
   input  wire logic        BREADY,
   input  wire logic [7:0]  ARADDR,
   input  wire logic        ARVALID,
   output logic             ARREADY,
   output logic [31:0]      RDATA,
   output logic [1:0]       RRESP,
   output logic             RVALID,
   input  wire logic        RREADY,
   // Receiver front-end indications
   input  wire logic        RX_TIMING_LOCK,
   input  wire logic        RX_FRAME_SYNC,
   input  wire logic        RX_MF_MARKER,
   input  wire logic        RX_EC_CONVERGED,
   input  wire logic        RX_SIGNAL_OK,
   input  wire logic        RX_READY_BIT,
   input  wire logic        RX_DEA_BIT,
   input  wire logic        RX_SUPERFRAME,
   input  wire logic [7:0]  RX_CHAN_DATA,
   input  wire logic        RX_CHAN_VALID,
   // Transmit framer
   input  wire logic        TX_SUPERFRAME,
   input  wire logic        TX_SYMBOL_TICK,
   output logic [1:0]       TX_PATTERN,
   output logic [1:0]       TX_TONE_SYMBOL,
   output logic             TX_USE_MF_WORD,
   output logic             TX_OVERHEAD_NORMAL,
   output logic             TX_READY_BIT,
   output logic             TX_DEA_BIT,
   output logic [7:0]       TX_CHAN_DATA,
   output logic [7:0]       NET_CHAN_DATA,
   output logic             TX_ACTIVE
);
   bra_pkg::line_state_t state;
   bra_pkg::line_state_t next_state;
   logic [31:0] control;
   logic [7:0]  tx_word;
   logic        tx_word_valid;
   logic        fifo_in_ready;
   logic [7:0]  fifo_data;
   logic        fifo_valid;
   logic        fifo_pop;
   logic [2:0]  tone_count;
   logic [31:0] loss_count;
   logic        ready_shown;
   logic [1:0]  ready_repeat;
   logic [1:0]  dea_repeat;
   logic        transparent;
   logic [7:0]  rx_word;

   // Control field decode
   wire enable       = control[`CTL_ENABLE];
   wire nt_side      = control[`CTL_NT_SIDE];
   wire local_ready  = control[`CTL_LOCAL_READY];
   wire start        = control[`CTL_START];
   wire announce_off = control[`CTL_ANNOUNCE_OFF];
   wire loopback     = control[`CTL_LOOPBACK];

   // Full operational status, same test both ends
   wire operational = RX_TIMING_LOCK && RX_FRAME_SYNC && RX_MF_MARKER && RX_EC_CONVERGED;
   // Transparency conditions per side
   wire nt_transp_ok = operational && RX_READY_BIT && RX_DEA_BIT;
   wire lt_transp_ok = operational && RX_MF_MARKER && RX_READY_BIT;
   wire transp_ok    = (state == bra_pkg::ST_FINAL) && (nt_side ? nt_transp_ok : lt_transp_ok);
   wire [7:0] fill   = nt_side ? `FILL_NT : `FILL_LT;
   // Line side raises its readiness only once the customer side shows ready,
   // so that the readiness edge and the switch to live data share one super frame
   wire want_ready   = local_ready && (state == bra_pkg::ST_FINAL) && (nt_side || RX_READY_BIT);

   // Write and read decode
   wire wr_fire   = AWVALID && WVALID && AWREADY && WREADY;
   wire wr_ctl    = wr_fire && (AWADDR == `REG_CONTROL);
   wire wr_data   = wr_fire && (AWADDR == `REG_TX_DATA);
   wire wr_known  = (AWADDR == `REG_CONTROL) || (AWADDR == `REG_TX_DATA);
   wire rd_fire   = ARVALID && ARREADY;
   wire rd_ctl    = (ARADDR == `REG_CONTROL);
   wire rd_stat   = (ARADDR == `REG_STATUS);
   wire rd_rx     = (ARADDR == `REG_RX_DATA);
   wire rd_flags  = (ARADDR == `REG_FLAGS);
   wire rd_known  = rd_ctl || rd_stat || rd_rx || rd_flags;
   wire [31:0] status_word = {20'h0, 2'(ready_repeat), transparent, TX_ACTIVE, state, TX_PATTERN};
   wire [31:0] flag_word   = {25'h0, RX_SIGNAL_OK, RX_DEA_BIT, RX_READY_BIT, RX_EC_CONVERGED,
                              RX_MF_MARKER, RX_FRAME_SYNC, RX_TIMING_LOCK};
   wire [31:0] rd_value    = rd_ctl ? control : rd_stat ? status_word : rd_rx ? {24'h0, rx_word} :
                             rd_flags ? flag_word : 32'h0;

   // Write channel: takes address and data together, answers after
   always_ff @(posedge CLK) begin
      if (RST) begin
         AWREADY <= 1'b0;
         WREADY  <= 1'b0;
         BVALID  <= 1'b0;
         BRESP   <= 2'b00;
      end else begin
         AWREADY <= AWVALID && WVALID && !AWREADY && !BVALID && (fifo_in_ready || !wr_known ||
                    AWADDR != `REG_TX_DATA);
         WREADY  <= AWVALID && WVALID && !AWREADY && !BVALID && (fifo_in_ready || !wr_known ||
                    AWADDR != `REG_TX_DATA);
         if (wr_fire) begin
            BVALID <= 1'b1;
            BRESP  <= wr_known ? 2'b00 : 2'b10;
         end else if (BREADY) begin
            BVALID <= 1'b0;
         end
      end
   end

   // Control register with byte strobes
   always_ff @(posedge CLK) begin
      if (RST) begin
         control <= `CTL_RESET_VALUE;
      end else if (wr_ctl) begin
         for (int i = 0; i < 4; i++) begin
            if (WSTRB[i]) control[i*8 +: 8] <= WDATA[i*8 +: 8];
         end
      end
   end
   assign tx_word       = WDATA[7:0];
   assign tx_word_valid = wr_data;

   // Read channel
   always_ff @(posedge CLK) begin
      if (RST) begin
         ARREADY <= 1'b0;
         RVALID  <= 1'b0;
         RDATA   <= 32'h0;
         RRESP   <= 2'b00;
      end else begin
         ARREADY <= ARVALID && !ARREADY && !RVALID;
         if (rd_fire) begin
            RVALID <= 1'b1;
            RDATA  <= rd_value;
            RRESP  <= rd_known ? 2'b00 : 2'b10;
         end else if (RREADY) begin
            RVALID <= 1'b0;
         end
      end
   end

   // Outgoing channel data buffer, drained one word per symbol tick while transparent
   bra_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk       (CLK),
      .rst       (RST),
      .in_data   (tx_word),
      .in_valid  (tx_word_valid),
      .in_ready  (fifo_in_ready),
      .out_data  (fifo_data),
      .out_valid (fifo_valid),
      .out_ready (fifo_pop)
   );
   assign fifo_pop = TX_SYMBOL_TICK && transparent;

   // Start-up sequence; final pattern holds until turned off or the signal loss timer expires
   always_comb begin
      next_state = state;
      case (state)
         bra_pkg::ST_IDLE:  if (enable && start) next_state = bra_pkg::ST_TONE;
         bra_pkg::ST_TONE:  if (RX_FRAME_SYNC) next_state = bra_pkg::ST_SYNC;
         bra_pkg::ST_SYNC:  if (operational) next_state = bra_pkg::ST_FINAL;
         bra_pkg::ST_FINAL: begin
            if (loss_count >= 32'(LOSS_CYCLES)) next_state = bra_pkg::ST_RXRST;
            else if (!nt_side && announce_off && dea_repeat == 2'(`REPEAT_MF)
                     && TX_SUPERFRAME) next_state = bra_pkg::ST_OFF;
            else if (!enable) next_state = bra_pkg::ST_OFF;
         end
         bra_pkg::ST_OFF:   if (!RX_SIGNAL_OK) next_state = bra_pkg::ST_IDLE;
         bra_pkg::ST_RXRST: if (!start) next_state = bra_pkg::ST_IDLE;
         default:           next_state = bra_pkg::ST_IDLE;
      endcase
   end

   // State register and loss timer
   always_ff @(posedge CLK) begin
      if (RST) begin
         state      <= bra_pkg::ST_IDLE;
         loss_count <= 32'h0;
      end else begin
         state      <= next_state;
         loss_count <= (state == bra_pkg::ST_FINAL && !(RX_SIGNAL_OK && RX_FRAME_SYNC)) ?
                       loss_count + 32'h1 : 32'h0;
      end
   end

   // Tone: four +3 then four -3, no frame word
   always_ff @(posedge CLK) begin
      if (RST) begin
         tone_count     <= 3'h0;
         TX_TONE_SYMBOL <= `SYM_PLUS3;
      end else if (state == bra_pkg::ST_TONE && TX_SYMBOL_TICK) begin
         tone_count     <= tone_count + 3'h1;
         TX_TONE_SYMBOL <= (tone_count < `TONE_HALF) ? `SYM_PLUS3 : `SYM_MINUS3;
      end
   end

   // Readiness bit: held three multiframes per change
   always_ff @(posedge CLK) begin
      if (RST) begin
         ready_shown  <= 1'b0;
         ready_repeat <= 2'h0;
      end else if (state != bra_pkg::ST_FINAL) begin
         ready_shown  <= 1'b0;
         ready_repeat <= 2'h0;
      end else if (TX_SUPERFRAME) begin
         if (ready_repeat != 2'h0) begin
            ready_repeat <= ready_repeat - 2'h1;
         end else if (ready_shown != want_ready) begin
            ready_shown  <= want_ready;
            ready_repeat <= 2'(`REPEAT_MF - 1);
         end
      end
   end

   // Deactivation announce counts multiframes sent at zero
   always_ff @(posedge CLK) begin
      if (RST) begin
         dea_repeat <= 2'h0;
      end else if (!announce_off) begin
         dea_repeat <= 2'h0;
      end else if (TX_SUPERFRAME && dea_repeat != 2'(`REPEAT_MF)) begin
         dea_repeat <= dea_repeat + 2'h1;
      end
   end

   // Line side transparency boundary: first ready-one super frame
   always_ff @(posedge CLK) begin
      if (RST) begin
         transparent    <= 1'b0;
      end else begin
         if (!transp_ok || loopback) transparent <= 1'b0;
         else if (nt_side) transparent <= 1'b1;
         else if (TX_SUPERFRAME) transparent <= 1'b1;
      end
   end

   // Transmit framer controls and both channel selectors
   always_ff @(posedge CLK) begin
      if (RST) begin
         TX_PATTERN         <= bra_pkg::PAT_SILENT;
         TX_USE_MF_WORD     <= 1'b0;
         TX_OVERHEAD_NORMAL <= 1'b0;
         TX_READY_BIT       <= 1'b0;
         TX_DEA_BIT         <= 1'b0;
         TX_CHAN_DATA       <= 8'h00;
         NET_CHAN_DATA      <= 8'h00;
         TX_ACTIVE          <= 1'b0;
         rx_word            <= 8'h00;
      end else begin
         TX_PATTERN <= (state == bra_pkg::ST_TONE) ? bra_pkg::PAT_TONE :
                       (state == bra_pkg::ST_SYNC) ? bra_pkg::PAT_SYNC :
                       (state == bra_pkg::ST_FINAL) ? bra_pkg::PAT_FINAL : bra_pkg::PAT_SILENT;
         // Customer sync pattern has marker absent; line sync has it present
         TX_USE_MF_WORD     <= (state == bra_pkg::ST_FINAL) ||
                               (state == bra_pkg::ST_SYNC && !nt_side);
         TX_OVERHEAD_NORMAL <= (state == bra_pkg::ST_FINAL) ||
                               (state == bra_pkg::ST_SYNC && !nt_side);
         TX_READY_BIT       <= ready_shown && (state == bra_pkg::ST_FINAL);
         TX_DEA_BIT         <= !nt_side && !announce_off && state == bra_pkg::ST_FINAL;
         TX_ACTIVE          <= (state != bra_pkg::ST_IDLE) && (state != bra_pkg::ST_OFF) &&
                               (state != bra_pkg::ST_RXRST);
         TX_CHAN_DATA       <= loopback ? RX_CHAN_DATA :
                               (transparent && fifo_valid) ? fifo_data : fill;
         NET_CHAN_DATA      <= transparent ? RX_CHAN_DATA : fill;
         if (RX_CHAN_VALID && transparent) rx_word <= RX_CHAN_DATA;
      end
   end
endmodule

/* File: logic/bra_pkg.sv */
package bra_pkg;
   typedef enum logic [5:0] {
      ST_IDLE   = 6'b000001,
      ST_TONE   = 6'b000010,
      ST_SYNC   = 6'b000100,
      ST_FINAL  = 6'b001000,
      ST_OFF    = 6'b010000,
      ST_RXRST  = 6'b100000
   } line_state_t;
   typedef enum logic [1:0] {
      PAT_SILENT  = 2'h0,
      PAT_TONE    = 2'h1,
      PAT_SYNC    = 2'h2,
      PAT_FINAL   = 2'h3
   } pattern_t;
endpackage

/* File: testbench/basic_rate_line_activation_transparency_test.sv */
`timescale 1ns/1ns
`include "bra_defs.svh"
module basic_rate_line_activation_transparency_test;
   localparam int LOSS = 50;
   logic        clk = 1'b0, rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0, link_up = 1'b0, far_ready = 1'b0;
   logic        sig_ok = 1'b1, sf = 1'b0, tick = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00, prev_chan = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic        awready, wready, bvalid, arready, rvalid, use_mf, ovh, tx_rdy, tx_dea, tx_act;
   logic        t_lock, f_sync, marker, ec_conv, rx_rdy, rx_dea, rx_valid;
   logic [1:0]  bresp, rresp, tx_pat, tx_tone;
   logic [7:0]  tx_chan, net_chan, rx_chan;
   logic [1:0]  tone[12];
   logic [33:0] exp_q[$];
   logic [7:0]  txq[$];
   int          error_cnt = 0, tests_run = 0, cyc = 0, k = 0;
   bra_line_ctrl #(.LOSS_CYCLES(LOSS), .FIFO_DEPTH(4)) bra_line_ctrl_inst (.CLK(clk), .RST(rst),
      .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hf),
      .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
      .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
      .RVALID(rvalid), .RREADY(rready), .RX_TIMING_LOCK(t_lock), .RX_FRAME_SYNC(f_sync),
      .RX_MF_MARKER(marker), .RX_EC_CONVERGED(ec_conv), .RX_SIGNAL_OK(sig_ok), .RX_READY_BIT(rx_rdy),
      .RX_DEA_BIT(rx_dea), .RX_SUPERFRAME(1'b0), .RX_CHAN_DATA(rx_chan), .RX_CHAN_VALID(rx_valid),
      .TX_SUPERFRAME(sf), .TX_SYMBOL_TICK(tick), .TX_PATTERN(tx_pat), .TX_TONE_SYMBOL(tx_tone),
      .TX_USE_MF_WORD(use_mf), .TX_OVERHEAD_NORMAL(ovh), .TX_READY_BIT(tx_rdy), .TX_DEA_BIT(tx_dea),
      .TX_CHAN_DATA(tx_chan), .NET_CHAN_DATA(net_chan), .TX_ACTIVE(tx_act));
   bra_far_end bra_far_end_inst (.clk(clk), .link_up(link_up), .far_ready(far_ready), .signal_ok(sig_ok),
      .tick(tick), .timing_lock(t_lock), .frame_sync(f_sync), .mf_marker(marker), .ec_conv(ec_conv),
      .ready_bit(rx_rdy), .dea_bit(rx_dea), .chan_data(rx_chan), .chan_valid(rx_valid));
   always #50 clk = ~clk;
   task automatic end_of_test();
      $display("errors %0d comparisons %0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Bus writes and reads; the answer is judged by the watcher below
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
      exp_q.push_back({resp, 32'h0});
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      @(posedge clk);
      while (!(awready && wready)) @(posedge clk);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      @(posedge clk);
      while (!bvalid) @(posedge clk);
      bready <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [33:0] e);
      exp_q.push_back(e);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      @(posedge clk);
      while (!arready) @(posedge clk);
      arvalid <= 1'b0;
      @(posedge clk);
      while (!rvalid) @(posedge clk);
      rready <= 1'b0;
      @(posedge clk);
   endtask
   task automatic send(input logic [7:0] b);
      txq.push_back(b);
      wr(`REG_TX_DATA, {24'h0, b}, 2'b00);
   endtask
   // Framer timing, timeout, bus answers and line bytes against their notes
   always @(posedge clk) begin
      cyc <= cyc + 1;
      tick <= (cyc % 4) == 3;
      sf <= (cyc % 64) == 63;
      prev_chan <= tx_chan;
      if (bvalid && bready) check("write response", {bresp, 32'h0}, exp_q.pop_front());
      if (rvalid && rready) check("read answer", {rresp, rdata}, exp_q.pop_front());
      if (tx_chan !== prev_chan && !(tx_chan inside {8'h00, 8'hff}) && txq.size() != 0)
         check("line byte", 34'(tx_chan), 34'(txq.pop_front()));
      if (cyc > 20000) begin
         error_cnt++;
         end_of_test();
      end
   end
   initial begin
      int n;
      void'($urandom(34));
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(`REG_CONTROL, 34'(`CTL_RESET_VALUE));
      rd(`REG_STATUS, 34'({bra_pkg::ST_IDLE, 2'h0}));
      rd(8'h14, {2'b10, 32'h0});
      wr(8'h14, 32'h0, 2'b10);
      // Line side: tone, then bring-up with fixed fill
      wr(`REG_CONTROL, 32'h9, 2'b00);
      for (n = 0; n < 50 && tx_pat !== bra_pkg::PAT_TONE; n++) @(posedge clk);
      repeat (2) @(posedge clk iff tick);
      for (n = 0; n < 12; n++) begin
         @(posedge clk iff tick);
         tone[n] = tx_tone;
      end
      for (n = 0; n < 8; n++) check("tone run", 34'(tone[n + 4]), 34'(tone[n] ^ 2'b10));
      link_up <= 1'b1;
      for (n = 0; n < 300 && tx_pat !== bra_pkg::PAT_FINAL; n++) @(posedge clk);
      @(posedge clk);
      check("final overhead", 34'({ovh, use_mf}), 34'(2'b11));
      wr(`REG_CONTROL, 32'hd, 2'b00);
      for (n = 1; n < 5; n++) send(8'(8'ha0 + n));
      repeat (130) @(posedge clk);
      check("line fill", 34'(tx_chan), 34'(`FILL_LT));
      fork
         send(8'ha5);
         begin
            repeat (20) @(posedge clk);
            check("full buffer refuses", 34'(bvalid), 34'(1'b0));
            far_ready <= 1'b1;
            for (n = 0; n < 400 && tx_chan === `FILL_LT; n++) begin
               @(posedge clk);
               k = k + int'(sf && tx_rdy);
            end
            check("transparent by second ready frame", 34'(k), 34'(0));
         end
      join
      for (n = 0; n < 400 && txq.size() != 0; n++) @(posedge clk);
      check("buffer drained", 34'(txq.size()), 34'(0));
      for (n = 0; n < 500 && net_chan === 8'h00; n++) @(posedge clk);
      check("network side live", 34'(net_chan !== 8'h00), 34'(1));
      check("ready sent", 34'(tx_rdy), 34'(1'b1));
      wr(`REG_CONTROL, 32'h9, 2'b00);
      for (n = 0; n < 400 && tx_rdy !== 1'b0; n++) @(posedge clk);
      check("ready cleared", 34'(tx_rdy), 34'(1'b0));
      // Announced turn-off
      check("announce idle high", 34'(tx_dea), 34'(1'b1));
      wr(`REG_CONTROL, 32'h19, 2'b00);
      k = 0;
      for (n = 0; n < 1000 && tx_act === 1'b1; n++) begin
         @(posedge clk);
         k = k + int'(sf && !tx_dea);
      end
      check("announce frames", 34'(k >= 3 && tx_act === 1'b0), 34'(1));
      sig_ok <= 1'b0;
      link_up <= 1'b0;
      far_ready <= 1'b0;
      wr(`REG_CONTROL, 32'h0, 2'b00);
      sig_ok <= 1'b1;
      // Customer side: unmarked sync pattern, fill of ones, then transparency
      wr(`REG_CONTROL, 32'hf, 2'b00);
      for (n = 0; n < 50 && tx_pat !== bra_pkg::PAT_TONE; n++) @(posedge clk);
      link_up <= 1'b1;
      for (n = 0; n < 100 && tx_pat !== bra_pkg::PAT_SYNC; n++) @(posedge clk);
      @(posedge clk);
      check("sync frame word", 34'(use_mf), 34'(1'b0));
      send(8'h42);
      for (n = 0; n < 300 && tx_pat !== bra_pkg::PAT_FINAL; n++) @(posedge clk);
      repeat (20) @(posedge clk);
      check("customer fill", 34'(tx_chan), 34'(`FILL_NT));
      far_ready <= 1'b1;
      for (n = 0; n < 30 && txq.size() != 0; n++) @(posedge clk);
      check("customer transparent", 34'(txq.size()), 34'(0));
      rd(`REG_FLAGS, 34'h7f);
      // Loopback echoes the line and keeps the network side on fill
      wr(`REG_CONTROL, 32'h2f, 2'b00);
      @(posedge clk iff tick);
      check("loopback echo", 34'(tx_chan), 34'(rx_chan));
      check("loopback network fill", 34'(net_chan), 34'(`FILL_NT));
      wr(`REG_CONTROL, 32'hf, 2'b00);
      // Signal loss in the final pattern
      sig_ok <= 1'b0;
      repeat (LOSS - 5) @(posedge clk);
      check("still active", 34'(tx_act), 34'(1'b1));
      for (n = 0; n < 30 && tx_act !== 1'b0; n++) @(posedge clk);
      check("stopped on loss", 34'(tx_act), 34'(1'b0));
      end_of_test();
   end
endmodule
bind bra_line_ctrl bra_line_ctrl_properties #(.LOSS_CYCLES(LOSS_CYCLES)) bra_line_ctrl_properties_inst (
   .CLK, .RST, .AWREADY, .BVALID, .ARREADY, .RVALID, .RX_SIGNAL_OK, .TX_SUPERFRAME, .TX_PATTERN,
   .TX_TONE_SYMBOL, .TX_USE_MF_WORD, .TX_OVERHEAD_NORMAL, .TX_READY_BIT, .TX_CHAN_DATA, .TX_ACTIVE);

/* File: testbench/bra_far_end.sv */
`timescale 1ns/1ns
module bra_far_end (
   input  wire logic       clk,
   input  wire logic       link_up,
   input  wire logic       far_ready,
   input  wire logic       signal_ok,
   input  wire logic       tick,
   output logic            timing_lock,
   output logic            frame_sync,
   output logic            mf_marker,
   output logic            ec_conv,
   output logic            ready_bit,
   output logic            dea_bit,
   output logic [7:0]      chan_data,
   output logic            chan_valid
);
   int up_cnt = 0;
   initial chan_data = 8'h5a;
   // Acquisition count, and a byte per symbol slot while the line runs
   always @(posedge clk) begin
      up_cnt <= (link_up && signal_ok) ? up_cnt + 1 : 0;
      chan_valid <= link_up && tick;
      if (link_up && tick) chan_data <= 8'($urandom_range(254, 1));
      else if (!link_up) chan_data <= ~chan_data; // Released line holds no value
   end
   // Timing first, frame word next, marker and convergence much later
   assign timing_lock = up_cnt > 2;
   assign frame_sync  = up_cnt > 4;
   assign mf_marker   = up_cnt > 40;
   assign ec_conv     = up_cnt > 40;
   assign ready_bit   = far_ready && mf_marker;
   assign dea_bit     = link_up;
endmodule

/* File: testbench/bra_line_ctrl_properties.sv */
`timescale 1ns/1ns
module bra_line_ctrl_properties #(
   parameter int LOSS_CYCLES = 50
) (
   input wire logic       CLK,
   input wire logic       RST,
   input wire logic       AWREADY,
   input wire logic       BVALID,
   input wire logic       ARREADY,
   input wire logic       RVALID,
   input wire logic       RX_SIGNAL_OK,
   input wire logic       TX_SUPERFRAME,
   input wire logic [1:0] TX_PATTERN,
   input wire logic [1:0] TX_TONE_SYMBOL,
   input wire logic       TX_USE_MF_WORD,
   input wire logic       TX_OVERHEAD_NORMAL,
   input wire logic       TX_READY_BIT,
   input wire logic [7:0] TX_CHAN_DATA,
   input wire logic       TX_ACTIVE
);
   logic [1:0]  rdy_sf;
   logic [15:0] loss_cnt;
   // Super frames since the readiness bit last moved; cycles of lost signal in the final pattern
   always_ff @(posedge CLK) begin
      if (RST) rdy_sf <= 2'h3;
      else if ($changed(TX_READY_BIT)) rdy_sf <= 2'h0;
      else if (TX_SUPERFRAME && rdy_sf != 2'h3) rdy_sf <= rdy_sf + 2'h1;
      if (RST || RX_SIGNAL_OK || TX_PATTERN != bra_pkg::PAT_FINAL) loss_cnt <= 16'h0;
      else if (loss_cnt != 16'hffff) loss_cnt <= loss_cnt + 16'h1;
   end
   AST_TONE_SHAPE: assert property (@(posedge CLK) disable iff (RST)
      TX_PATTERN == bra_pkg::PAT_TONE |-> !TX_USE_MF_WORD && TX_TONE_SYMBOL inside {2'b01, 2'b11})
      else $error("tone carries a frame word or a bad symbol");
   AST_FINAL_OVERHEAD: assert property (@(posedge CLK) disable iff (RST)
      TX_PATTERN == bra_pkg::PAT_FINAL |-> TX_OVERHEAD_NORMAL && TX_USE_MF_WORD)
      else $error("final pattern without normal overhead");
   AST_FILL_OUTSIDE_FINAL: assert property (@(posedge CLK) disable iff (RST)
      TX_PATTERN != bra_pkg::PAT_FINAL |-> TX_CHAN_DATA inside {8'h00, 8'hff})
      else $error("channel data live outside the final pattern");
   AST_FINAL_HOLDS: assert property (@(posedge CLK) disable iff (RST)
      TX_PATTERN == bra_pkg::PAT_FINAL && TX_ACTIVE |=> TX_PATTERN == bra_pkg::PAT_FINAL || !TX_ACTIVE)
      else $error("final pattern left while still active");
   AST_READY_REPEAT: assert property (@(posedge CLK) disable iff (RST)
      $changed(TX_READY_BIT) && TX_ACTIVE |-> rdy_sf == 2'h3)
      else $error("readiness bit changed before three multiframes");
   AST_LOSS_STOP: assert property (@(posedge CLK) disable iff (RST)
      loss_cnt <= LOSS_CYCLES + 4)
      else $error("final pattern kept after signal loss timeout");
   AST_READY_ONLY_FINAL: assert property (@(posedge CLK) disable iff (RST)
      TX_PATTERN != bra_pkg::PAT_FINAL |-> !TX_READY_BIT)
      else $error("readiness bit set outside the final pattern");
   AST_WRITE_ANSWER: assert property (@(posedge CLK) disable iff (RST)
      $rose(AWREADY) |=> BVALID)
      else $error("write response late");
   AST_READ_ANSWER: assert property (@(posedge CLK) disable iff (RST)
      $rose(ARREADY) |=> RVALID)
      else $error("read data late");
endmodule
